// File: urx_pkg.sv
package urx_pkg;
  // register indices on the plain register port
  localparam logic [2:0] URX_ADDR_CTRL_ONE = 3'h0;
  localparam logic [2:0] URX_ADDR_CTRL_TWO = 3'h1;
  localparam logic [2:0] URX_ADDR_STATUS_ONE = 3'h2;
  localparam logic [2:0] URX_ADDR_DATA = 3'h3;
  localparam logic [2:0] URX_ADDR_BAUD_DIV = 3'h4;

  // control_one fields
  localparam int URX_C1_NINE_BIT = 0;
  localparam int URX_C1_RX_EN = 1;
  // status_one fields; control_two uses the same layout as the interrupt mask
  localparam int URX_ST_FULL = 0;
  localparam int URX_ST_NOISE = 1;
  localparam int URX_ST_FRAME = 2;
  localparam int URX_ST_BREAK = 3;
  localparam int URX_ST_NINTH = 4;
  localparam int URX_FLAG_W = 4;

  // reset values
  localparam logic [7:0] URX_CTRL_ONE_RST = 8'h02;
  localparam logic [3:0] URX_CTRL_TWO_RST = 4'h0;
  localparam logic [7:0] URX_BAUD_DIV_RST = 8'h81;

  // sample tick positions within one bit period
  localparam logic [4:0] URX_T_FIRST = 5'h01;
  localparam logic [4:0] URX_T_S3 = 5'h03;
  localparam logic [4:0] URX_T_S5 = 5'h05;
  localparam logic [4:0] URX_T_S7 = 5'h07;
  localparam logic [4:0] URX_T_V8 = 5'h08;
  localparam logic [4:0] URX_T_V9 = 5'h09;
  localparam logic [4:0] URX_T_V10 = 5'h0a;
  localparam logic [4:0] URX_T_LAST = 5'h10;
  localparam logic [3:0] URX_BITS_8 = 4'h8;
  localparam logic [3:0] URX_BITS_9 = 4'h9;

  typedef enum logic [1:0] {URX_SEARCH, URX_START, URX_DATA, URX_STOP} urx_state_t;

  // two out of three vote
  function automatic logic urx_major(input logic [2:0] s);
    urx_major = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : urx_major

  // samples not all equal
  function automatic logic urx_noisy(input logic [2:0] s);
    urx_noisy = (s != 3'h0) && (s != 3'h7);
  endfunction : urx_noisy
endpackage : urx_pkg

// File: urx_tick_gen.sv
`timescale 1ns/100ps
module urx_tick_gen import urx_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic [7:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } urx_tg_t;

  urx_tg_t st_r;
  urx_tg_t st_nxt;

  // one tick every divisor+1 clocks gives sixteen ticks per bit
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = 8'h00;
    end else if (st_r.cnt >= divisor) begin
      st_nxt.cnt = 8'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : urx_tick_gen

// File: urx_receiver.sv
`timescale 1ns/100ps
module urx_receiver import urx_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic rx_pin,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq
);
  typedef struct packed {
    logic [1:0] sync;
    urx_state_t state;
    logic [4:0] tick_cnt;
    logic [3:0] bit_idx;
    logic [2:0] hist;
    logic [2:0] start_smp;
    logic [2:0] vote_smp;
    logic prev_smp;
    logic last_maj;
    logic edge_seen;
    logic [4:0] edge_off;
    logic [8:0] shift;
    logic [7:0] rx_data_buffer;
    logic ninth_rx_bit;
    logic [URX_FLAG_W-1:0] flags;
    logic [7:0] control_one;
    logic [URX_FLAG_W-1:0] control_two;
    logic [7:0] baud_div;
    logic [7:0] rdata;
  } urx_regs_t;

  urx_regs_t st_r;
  urx_regs_t st_nxt;
  logic tick;
  logic rx_s;
  logic nine_bit;
  logic [3:0] data_bits;
  logic maj;
  logic [URX_FLAG_W-1:0] set_f;
  logic [URX_FLAG_W-1:0] clr_f;

  ////////////////////////////////////////////////////////////////////////////
  // sample tick source
  urx_tick_gen u_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .run(st_r.control_one[URX_C1_RX_EN]),
    .divisor(st_r.baud_div),
    .tick(tick)
  );

  assign rx_s = st_r.sync[1];
  assign nine_bit = st_r.control_one[URX_C1_NINE_BIT];
  assign data_bits = nine_bit ? URX_BITS_9 : URX_BITS_8;
  // vote uses the two earlier samples plus the one taken at tick 10
  assign maj = urx_major({st_r.vote_smp[1:0], rx_s});

  ////////////////////////////////////////////////////////////////////////////
  // receive sequencer, flags and register port
  always_comb begin
    st_nxt = st_r;
    set_f = '0;
    clr_f = '0;
    st_nxt.rdata = 8'h00;
    // pin crosses two flops before anything looks at it
    st_nxt.sync = {st_r.sync[0], rx_pin};

    if (!st_r.control_one[URX_C1_RX_EN]) begin
      st_nxt.state = URX_SEARCH;
      st_nxt.tick_cnt = 5'h00;
      st_nxt.hist = 3'h0;
    end else if (tick) begin
      st_nxt.prev_smp = rx_s;
      // tick counts 1..16; wrap moves to the next bit
      if (st_r.state != URX_SEARCH) begin
        if (st_r.tick_cnt == URX_T_LAST) begin
          st_nxt.tick_cnt = URX_T_FIRST;
          st_nxt.bit_idx = st_r.bit_idx + 4'h1;
          if (st_r.bit_idx == data_bits) begin
            st_nxt.state = URX_STOP;
          end else begin
            st_nxt.state = URX_DATA;
          end
        end else begin
          st_nxt.tick_cnt = st_r.tick_cnt + 5'h01;
        end
      end
      // vote sample capture, shared by every bit
      if (st_r.tick_cnt == URX_T_V8 || st_r.tick_cnt == URX_T_V9) begin
        st_nxt.vote_smp = {st_r.vote_smp[1:0], rx_s};
      end
      case (st_r.state)
        URX_SEARCH: begin
          st_nxt.hist = {st_r.hist[1:0], rx_s};
          // low after three highs opens a start bit at tick 1
          if (!rx_s && st_r.hist == 3'h7) begin
            st_nxt.state = URX_START;
            // this low sample is tick 1, so the next one is tick 2
            st_nxt.tick_cnt = URX_T_FIRST + 5'h01;
            st_nxt.bit_idx = 4'h0;
            // an eight-bit frame never reaches bit 0; clear it for the break test
            st_nxt.shift = 9'h000;
            st_nxt.start_smp = 3'h0;
            st_nxt.last_maj = 1'b0;
            st_nxt.edge_seen = 1'b0;
          end
        end
        URX_START: begin
          if (st_r.tick_cnt == URX_T_S3 || st_r.tick_cnt == URX_T_S5) begin
            st_nxt.start_smp = {st_r.start_smp[1:0], rx_s};
          end
          if (st_r.tick_cnt == URX_T_S7) begin
            // two or more highs among 3, 5, 7 reject the start
            if (urx_major({st_r.start_smp[1:0], rx_s})) begin
              st_nxt.state = URX_SEARCH;
              st_nxt.tick_cnt = 5'h00;
              st_nxt.hist = 3'h0;
            end else if ({st_r.start_smp[1:0], rx_s} != 3'h0) begin
              set_f[URX_ST_NOISE] = 1'b1;
            end
          end
          // late high samples are noise only, start is kept
          if (st_r.tick_cnt == URX_T_V10 && {st_r.vote_smp[1:0], rx_s} != 3'h0) begin
            set_f[URX_ST_NOISE] = 1'b1;
          end
        end
        URX_DATA, URX_STOP: begin
          // note a falling edge after a one bit for later resync
          if (st_r.prev_smp && !rx_s && !st_r.edge_seen) begin
            if (st_r.tick_cnt > URX_T_V10 && st_r.last_maj) begin
              st_nxt.edge_seen = 1'b1;
              st_nxt.edge_off = st_r.tick_cnt - 5'h11;
            end else if (st_r.tick_cnt <= URX_T_V10 && st_r.last_maj) begin
              st_nxt.edge_seen = 1'b1;
              st_nxt.edge_off = st_r.tick_cnt - 5'h01;
            end
          end
          if (st_r.tick_cnt == URX_T_V10) begin
            st_nxt.last_maj = maj;
            st_nxt.edge_seen = 1'b0;
            if (urx_noisy({st_r.vote_smp[1:0], rx_s})) begin
              set_f[URX_ST_NOISE] = 1'b1;
            end
            if (st_r.state == URX_DATA) begin
              st_nxt.shift = {maj, st_r.shift[8:1]};
              // one-to-zero change pulls tick 1 onto the seen edge;
              // a very early edge is clamped to a full bit
              if (st_r.last_maj && !maj && st_r.edge_seen) begin
                if ($signed(st_r.edge_off) < $signed(-5'sd5)) begin
                  st_nxt.tick_cnt = URX_T_LAST;
                end else begin
                  st_nxt.tick_cnt = 5'h0b - st_r.edge_off;
                end
              end
            end else begin
              // stop sample point: 9 or 10 bits plus ten ticks
              st_nxt.state = URX_SEARCH;
              st_nxt.tick_cnt = 5'h00;
              st_nxt.hist = 3'h0;
              set_f[URX_ST_FULL] = 1'b1;
              set_f[URX_ST_FRAME] = !maj;
              st_nxt.ninth_rx_bit = st_r.shift[8];
              if (nine_bit) begin
                st_nxt.rx_data_buffer = st_r.shift[7:0];
              end else begin
                st_nxt.rx_data_buffer = st_r.shift[8:1];
              end
              // all-zero data with a low stop is a break
              if (!maj && st_r.shift == 9'h000) begin
                set_f[URX_ST_BREAK] = 1'b1;
                st_nxt.rx_data_buffer = 8'h00;
                st_nxt.ninth_rx_bit = 1'b0;
              end
            end
          end
        end
        default: begin
          st_nxt.state = URX_SEARCH;
        end
      endcase
    end

    // register writes; status flag bits 3..0 clear on a written one, the ninth bit does not
    if (reg_wr) begin
      case (reg_addr)
        URX_ADDR_CTRL_ONE: st_nxt.control_one = reg_wdata;
        URX_ADDR_CTRL_TWO: st_nxt.control_two = reg_wdata[URX_FLAG_W-1:0];
        URX_ADDR_STATUS_ONE: clr_f = reg_wdata[URX_FLAG_W-1:0];
        URX_ADDR_BAUD_DIV: st_nxt.baud_div = reg_wdata;
        default: ;
      endcase
    end
    // a new event in the clear cycle survives
    st_nxt.flags = (st_r.flags & ~clr_f) | set_f;

    // read data stands for one cycle only; unmapped reads give zero
    if (reg_rd) begin
      case (reg_addr)
        URX_ADDR_CTRL_ONE: st_nxt.rdata = st_r.control_one;
        URX_ADDR_CTRL_TWO: st_nxt.rdata = {4'h0, st_r.control_two};
        URX_ADDR_STATUS_ONE: st_nxt.rdata = {3'h0, st_r.ninth_rx_bit, st_r.flags};
        URX_ADDR_DATA: st_nxt.rdata = st_r.rx_data_buffer;
        URX_ADDR_BAUD_DIV: st_nxt.rdata = st_r.baud_div;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; clock enable low freezes everything
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.sync <= 2'h3;
      st_r.state <= URX_SEARCH;
      st_r.control_one <= URX_CTRL_ONE_RST;
      st_r.control_two <= URX_CTRL_TWO_RST;
      st_r.baud_div <= URX_BAUD_DIV_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  // bit 0 of control_two is the receiver-full interrupt enable
  assign irq = |(st_r.flags & st_r.control_two);
endmodule : urx_receiver

// File: urx_line_tx.sv
`timescale 1ns/100ps
module urx_line_tx (
  input wire logic sys_clk,
  input wire logic [7:0] div,
  output logic line
);
  initial line = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // n ticks of line time; the line only moves just after a clock edge
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n * (int'(div) + 1)) @(posedge sys_clk);
  endtask : hold
  // lsb first; bit gb flips for one tick at offset gt (7..9 hits ticks 8..10),
  // so its vote holds but noise shows
  task automatic send(input logic [8:0] d, input logic nine, input logic stp, input int gb,
    input int gt);
    logic [10:0] f;
    f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    @(posedge sys_clk);
    for (int b = 0; b < (nine ? 11 : 10); b++) begin
      hold(f[b], gt);
      hold(f[b] ^ (b == gb), 1);
      hold(f[b], 15 - gt);
    end
    // long idle so the search sees plenty of high samples
    hold(1'b1, 600);
  endtask : send
  // a short low pulse that must not pass as a start bit
  task automatic pulse(input int n);
    @(posedge sys_clk);
    hold(1'b0, n);
    hold(1'b1, 600);
  endtask : pulse
endmodule : urx_line_tx

// File: urx_receiver_monitor.sv
`timescale 1ns/100ps
module urx_receiver_monitor import urx_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic rx_pin,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] c1_r;
  logic [3:0] mk_r;
  logic [9:0] hi_r;
  ////////////////////////////////////////////////////////////////////////////
  // register shadows; hi_r (512 high clocks) outlasts a whole frame at divisor 0 or 1, so when saturated no flag moves
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      c1_r <= URX_CTRL_ONE_RST;
      mk_r <= URX_CTRL_TWO_RST;
      hi_r <= 10'h000;
    end else if (ce) begin
      if (reg_wr && reg_addr == URX_ADDR_CTRL_ONE) c1_r <= reg_wdata;
      if (reg_wr && reg_addr == URX_ADDR_CTRL_TWO) mk_r <= reg_wdata[3:0];
      if (!rx_pin) hi_r <= 10'h000;
      else if (!hi_r[9]) hi_r <= hi_r + 10'h001;
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_reset_quiet: assert property ($rose(nrst) |-> reg_rdata == 8'h00 && !irq)
    else $error("outputs not cleared by reset");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > URX_ADDR_BAUD_DIV
    |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_ctrl_back: assert property ($past(reg_rd) && $past(reg_addr) == URX_ADDR_CTRL_ONE
    |-> reg_rdata == c1_r) else $error("control one readback");
  a_mask_back: assert property ($past(reg_rd) && $past(reg_addr) == URX_ADDR_CTRL_TWO
    |-> reg_rdata[3:0] == mk_r) else $error("control two readback");
  a_irq_masked: assert property (mk_r == 4'h0 |-> !irq)
    else $error("irq with all enables off");
  a_irq_status: assert property (hi_r[9] && $past(reg_rd) &&
    $past(reg_addr) == URX_ADDR_STATUS_ONE |-> irq == |(reg_rdata[3:0] & mk_r))
    else $error("irq disagrees with status");
  a_irq_steady: assert property (hi_r[9] && !$past(reg_wr) |-> $stable(irq))
    else $error("irq moved on idle line");
  c_irq_up: cover property ($rose(irq));
  c_frame_err: cover property ($past(reg_rd) && reg_rdata[URX_ST_FRAME]);
  c_break: cover property ($past(reg_rd) && reg_rdata[URX_ST_BREAK]);
endmodule : urx_receiver_monitor
bind urx_receiver urx_receiver_monitor mon (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
  .rx_pin(rx_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// File: uart_receiver_data_recovery_test.sv
`timescale 1ns/100ps
module uart_receiver_data_recovery_test import urx_pkg::*;;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic rx_pin;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic [7:0] bd = 8'h00;
  int fail_count = 0;
  int n_tests = 0;
  // 50 ns period
  always #25 sys_clk = ~sys_clk;
  urx_receiver uut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .rx_pin(rx_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  urx_line_tx tx (.sys_clk(sys_clk), .div(bd), .line(rx_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string m);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, m);
  endtask : rc
  // status expected after one frame
  function automatic logic [7:0] exp_st(logic [8:0] d, logic nine, logic stp, logic nz);
    logic brk;
    brk = !stp && d[7:0] == 8'h00 && !(nine && d[8]);
    exp_st = {3'h0, !brk && (nine ? d[8] : d[7]), brk, !stp, nz, 1'b1};
  endfunction : exp_st
  task automatic print_verdict();
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [8:0] d;
    logic nine;
    logic stp;
    logic [3:0] mk;
    logic [7:0] st;
    int gb;
    int gt;
    void'($urandom(32'h49f24ebb));
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rc(URX_ADDR_CTRL_ONE, URX_CTRL_ONE_RST, "ctrl one reset");
    rc(URX_ADDR_CTRL_TWO, 8'h00, "ctrl two reset");
    rc(URX_ADDR_BAUD_DIV, URX_BAUD_DIV_RST, "baud reset");
    rc(URX_ADDR_STATUS_ONE, 8'h00, "status reset");
    rc(3'h7, 8'h00, "unmapped");
    wr(URX_ADDR_BAUD_DIV, 8'h00);
    // clock enable low freezes the registers, so this write is lost
    ce <= 1'b0;
    wr(URX_ADDR_BAUD_DIV, 8'h5a);
    ce <= 1'b1;
    rc(URX_ADDR_BAUD_DIV, 8'h00, "frozen by ce");
    tx.pulse(4);
    rc(URX_ADDR_STATUS_ONE, 8'h00, "false start");
    // random frames with breaks, framing errors and noise mixed in
    for (int i = 0; i < 24; i++) begin
      bd = 8'($urandom_range(1));
      nine = 1'($urandom);
      d = 9'($urandom);
      stp = (i % 4) != 1;
      gb = (i % 3 == 0) ? int'($urandom_range(nine ? 10 : 9)) : -1;
      // the odd sample lands on any one of the three vote ticks
      gt = 7 + int'($urandom_range(2));
      if (i % 8 == 1) d = 9'h000;
      mk = 4'($urandom);
      wr(URX_ADDR_BAUD_DIV, bd);
      wr(URX_ADDR_CTRL_ONE, {6'h00, 1'b1, nine});
      wr(URX_ADDR_CTRL_TWO, {4'h0, mk});
      tx.send(d, nine, stp, gb, gt);
      st = exp_st(d, nine, stp, gb >= 0);
      rc(URX_ADDR_STATUS_ONE, st, "status");
      wr(URX_ADDR_DATA, 8'($urandom));
      rc(URX_ADDR_DATA, st[URX_ST_BREAK] ? 8'h00 : d[7:0], "data");
      chk({7'h00, irq}, {7'h00, |(st[3:0] & mk)}, "irq set");
      wr(URX_ADDR_STATUS_ONE, 8'h0f);
      rc(URX_ADDR_STATUS_ONE, {3'h0, st[4], 4'h0}, "status clear");
      chk({7'h00, irq}, 8'h00, "irq clear");
    end
    // a disabled receiver ignores a whole frame
    wr(URX_ADDR_CTRL_ONE, 8'h00);
    tx.send(9'h0a5, 1'b0, 1'b1, -1, 8);
    rc(URX_ADDR_STATUS_ONE, {3'h0, st[4], 4'h0}, "disabled");
    print_verdict();
  end
  // watchdog well beyond the longest expected run
  initial begin
    repeat (90000) @(posedge sys_clk);
    fail_count++;
    print_verdict();
  end
endmodule : uart_receiver_data_recovery_test
